// ### logic/prio_pkg.sv
// package: constants and types for the bus master priority configuration
// assumes a 32-bit register port and a twelve-master interconnect
package prio_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int PRIO_W = 3;
    localparam int NUM_MASTERS = 12;
    localparam int IDX_W = 4;

    // register addresses on the configuration bus
    localparam logic [ADDR_W-1:0] LEGACY_ADDR  = 32'h01C4003C;
    localparam logic [ADDR_W-1:0] CONTROL_ADDR = 32'h01C40040;

    // field positions of master_priority_control
    localparam int BRIDGE_LSB = 16;
    localparam int DISK_LSB   = 12;
    localparam int USBCFG_LSB = 8;

    // reset values and fixed priority levels
    localparam logic [PRIO_W-1:0] FIELD_RESET = 3'h4;
    localparam logic [PRIO_W-1:0] PRIO_HIGH   = 3'h0;
    localparam logic [PRIO_W-1:0] PRIO_MID    = 3'h4;
    localparam logic [PRIO_W-1:0] PRIO_LOW    = 3'h7;
    localparam logic [DATA_W-1:0] LEGACY_RESET = 32'h00000000;

    // master indices
    localparam int M_VIDEO  = 0;
    localparam int M_TC0    = 1;
    localparam int M_TC1    = 2;
    localparam int M_HDMA   = 3;
    localparam int M_HCFG   = 4;
    localparam int M_DSPDMA = 5;
    localparam int M_DSPCFG = 6;
    localparam int M_ETH    = 7;
    localparam int M_USB    = 8;
    localparam int M_DISK   = 9;
    localparam int M_BRIDGE = 10;
    localparam int M_ACCEL  = 11;

    // register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    // grant answer to the interconnect
    typedef struct packed {
        logic             valid;
        logic [IDX_W-1:0] index;
    } grant_t;
endpackage : prio_pkg

// ### logic/prio_arbiter.sv
// priority arbiter: lowest value wins, round robin among equals
// assumes request and priority vectors come from logic on core_clk
`timescale 1ns/1ps
`default_nettype none
module prio_arbiter (
    // clock and reset
    input  wire logic                                      core_clk,
    input  wire logic                                      reset_n,
    // requests and priorities
    input  wire logic [prio_pkg::NUM_MASTERS-1:0]           req,
    input  wire logic [prio_pkg::NUM_MASTERS*prio_pkg::PRIO_W-1:0] prio,
    // registered grant
    output var prio_pkg::grant_t                           grant
);
    prio_pkg::grant_t                  grant_next;
    logic [prio_pkg::IDX_W-1:0]        last_reg;

    localparam int W = prio_pkg::PRIO_W;

    // search from the master after the last winner, keep strictly lower
    always_comb begin
        logic [W-1:0] best;
        logic [W-1:0] cand;
        int           idx;
        best       = '1;
        cand       = '0;
        idx        = 0;
        grant_next = '0;
        for (int k = 1; k <= prio_pkg::NUM_MASTERS; k++) begin
            idx  = (int'(last_reg) + k) % prio_pkg::NUM_MASTERS;
            cand = prio[idx*W +: W];
            if (req[idx] && (!grant_next.valid || cand < best)) begin
                best             = cand;
                grant_next.valid = 1'b1;
                grant_next.index = prio_pkg::IDX_W'(idx);
            end
        end
    end

    // register grant and rotation pointer
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            grant    <= '0;
            last_reg <= '0;
        end else begin
            grant <= grant_next;
            if (grant_next.valid) begin
                last_reg <= grant_next.index;
            end
        end
    end
endmodule : prio_arbiter
`default_nettype wire

// ### logic/bus_master_priority_config.sv
// bus master priority configuration: register and arbitration
// assumes a one-cycle register port and request levels on core_clk
// assumes the interconnect reads master_prio and grant on core_clk
`timescale 1ns/1ps
`default_nettype none
module bus_master_priority_config (
    // clock and reset
    input  wire logic                                      core_clk,
    input  wire logic                                      reset_n,
    // register port
    input  wire logic [prio_pkg::ADDR_W-1:0]                reg_addr,
    input  wire logic [prio_pkg::DATA_W-1:0]                reg_wdata,
    input  wire logic                                      reg_wr,
    input  wire logic                                      reg_rd,
    output logic [prio_pkg::DATA_W-1:0]                     reg_rdata,
    // master requests and grant
    input  wire logic [prio_pkg::NUM_MASTERS-1:0]           master_req,
    output logic [prio_pkg::NUM_MASTERS*prio_pkg::PRIO_W-1:0] master_prio,
    output var prio_pkg::grant_t                           grant
);
    localparam int W = prio_pkg::PRIO_W;

    // where a master's priority comes from: a fixed default or a field
    typedef enum logic [1:0] {
        SRC_FIXED  = 2'h0,
        SRC_BRIDGE = 2'h1,
        SRC_DISK   = 2'h2,
        SRC_USBCFG = 2'h3
    } prio_src_t;

    // bundled register port
    prio_pkg::reg_req_t                 req;
    // address decode, one flag per register and strobe
    logic                               ctrl_wr_hit;
    logic                               ctrl_rd_hit;
    logic                               legacy_wr_hit;
    logic                               legacy_rd_hit;
    // priority fields of the control register
    logic [W-1:0]                       bridge_reg;
    logic [W-1:0]                       disk_reg;
    logic [W-1:0]                       usbcfg_reg;
    // legacy storage, read back only
    logic [prio_pkg::DATA_W-1:0]        legacy_reg;
    // read path
    logic [prio_pkg::DATA_W-1:0]        control_view;
    logic [prio_pkg::DATA_W-1:0]        rdata_next;
    // per-master priorities ahead of the output register
    logic [prio_pkg::NUM_MASTERS*W-1:0] prio_next;

    // bundle the register port
    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr,
                   wdata: reg_wdata};

    // full address decode, so near addresses never alias a register
    assign ctrl_wr_hit   = req.wr && (req.addr == prio_pkg::CONTROL_ADDR);
    assign ctrl_rd_hit   = req.rd && (req.addr == prio_pkg::CONTROL_ADDR);
    assign legacy_wr_hit = req.wr && (req.addr == prio_pkg::LEGACY_ADDR);
    assign legacy_rd_hit = req.rd && (req.addr == prio_pkg::LEGACY_ADDR);

    // bridge and accelerator field, bits written elsewhere are dropped
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bridge_reg <= prio_pkg::FIELD_RESET;
        end else if (ctrl_wr_hit) begin
            bridge_reg <= req.wdata[prio_pkg::BRIDGE_LSB +: W];
        end
    end

    // disk interface field
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            disk_reg <= prio_pkg::FIELD_RESET;
        end else if (ctrl_wr_hit) begin
            disk_reg <= req.wdata[prio_pkg::DISK_LSB +: W];
        end
    end

    // usb and dsp configuration field, shared by both masters
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            usbcfg_reg <= prio_pkg::FIELD_RESET;
        end else if (ctrl_wr_hit) begin
            usbcfg_reg <= req.wdata[prio_pkg::USBCFG_LSB +: W];
        end
    end

    // legacy register stores and reads back; its value goes nowhere
    // else, so software that still programs it sees no change in order
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            legacy_reg <= prio_pkg::LEGACY_RESET;
        end else if (legacy_wr_hit) begin
            legacy_reg <= req.wdata;
        end
    end

    // control view: reserved positions forced to zero, so what is
    // written there is lost and always reads back as zero
    always_comb begin
        control_view = '0;
        control_view[prio_pkg::BRIDGE_LSB +: W] = bridge_reg;
        control_view[prio_pkg::DISK_LSB +: W]   = disk_reg;
        control_view[prio_pkg::USBCFG_LSB +: W] = usbcfg_reg;
    end

    // read mux; unmapped addresses and idle cycles read zero
    always_comb begin
        rdata_next = '0;
        if (ctrl_rd_hit) begin
            rdata_next = control_view;
        end else if (legacy_rd_hit) begin
            rdata_next = legacy_reg;
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // per-master priorities; only fixed defaults and the control register fields feed
    // them, which is why the legacy register has no say in arbitration
    // a field shared by two masters moves both of them at once
    for (genvar m = 0; m < prio_pkg::NUM_MASTERS; m++) begin : g_master
        prio_src_t    src;
        logic [W-1:0] fixed_prio;
        logic [W-1:0] prio_sel;

        // source and fixed default of this master
        always_comb begin
            src        = SRC_FIXED;
            fixed_prio = prio_pkg::PRIO_MID;
            case (m)
                prio_pkg::M_VIDEO: begin
                    fixed_prio = prio_pkg::PRIO_HIGH;
                end
                prio_pkg::M_TC0: begin
                    fixed_prio = prio_pkg::PRIO_HIGH;
                end
                prio_pkg::M_TC1: begin
                    fixed_prio = prio_pkg::PRIO_HIGH;
                end
                prio_pkg::M_HDMA: begin
                    fixed_prio = prio_pkg::PRIO_MID;
                end
                prio_pkg::M_HCFG: begin
                    fixed_prio = prio_pkg::PRIO_MID;
                end
                prio_pkg::M_DSPDMA: begin
                    fixed_prio = prio_pkg::PRIO_LOW;
                end
                prio_pkg::M_ETH: begin
                    fixed_prio = prio_pkg::PRIO_MID;
                end
                prio_pkg::M_DSPCFG: begin
                    src = SRC_USBCFG;
                end
                prio_pkg::M_USB: begin
                    src = SRC_USBCFG;
                end
                prio_pkg::M_DISK: begin
                    src = SRC_DISK;
                end
                prio_pkg::M_BRIDGE: begin
                    src = SRC_BRIDGE;
                end
                prio_pkg::M_ACCEL: begin
                    src = SRC_BRIDGE;
                end
                default: begin
                    // no master sits here; keep the middle value
                    fixed_prio = prio_pkg::PRIO_MID;
                end
            endcase
        end

        // a field-fed master follows its field from the next edge on
        always_comb begin
            case (src)
                SRC_BRIDGE: prio_sel = bridge_reg;
                SRC_DISK:   prio_sel = disk_reg;
                SRC_USBCFG: prio_sel = usbcfg_reg;
                default:    prio_sel = fixed_prio;
            endcase
        end

        // each master owns its own slice of the priority vector
        assign prio_next[m*W +: W] = prio_sel;
    end

    // registered priority outputs
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_prio <= '0;
        end else begin
            master_prio <= prio_next;
        end
    end

    // arbitration on the registered priorities
    prio_arbiter u_arb (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .req      (master_req),
        .prio     (master_prio),
        .grant    (grant)
    );
endmodule : bus_master_priority_config
`default_nettype wire

// ### verification/prio_properties.sv
// checker: port-level properties of the priority configuration block
// assumes one clock domain and the one-cycle register read port
`timescale 1ns/1ps
`default_nettype none
module prio_checker (
    // clock and reset
    input wire logic             core_clk,
    input wire logic             reset_n,
    // register port
    input wire logic [31:0]      reg_addr,
    input wire logic [31:0]      reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [31:0]      reg_rdata,
    // masters
    input wire logic [11:0]      master_req,
    input wire logic [35:0]      master_prio,
    input wire prio_pkg::grant_t grant
);
    logic [11:0] req_q;
    logic [35:0] prio_q;
    logic [2:0]  best;
    // requests and priorities as the arbiter saw them
    always_ff @(posedge core_clk) begin
        req_q <= master_req;
        prio_q <= master_prio;
    end
    // lowest priority value among the sampled requests
    always_comb begin
        best = 3'h7;
        for (int i = 0; i < 12; i++)
            if (req_q[i] && prio_q[3*i+:3] < best)
                best = prio_q[3*i+:3];
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_ctrl_wr;
        reg_wr && reg_addr == prio_pkg::CONTROL_ADDR;
    endsequence
    sequence s_ctrl_rd;
        reg_rd && reg_addr == prio_pkg::CONTROL_ADDR;
    endsequence
    a_rsvd_zero: assert property (s_ctrl_rd |=>
        reg_rdata[31:19] == 0 && reg_rdata[15] == 0 && reg_rdata[11] == 0
        && reg_rdata[7:0] == 0) else $error("reserved bits not zero");
    a_field_mirror: assert property (s_ctrl_rd |=>
        reg_rdata[10:8] == master_prio[26:24] && master_prio[20:18] ==
        reg_rdata[10:8] && reg_rdata[14:12] == master_prio[29:27] &&
        reg_rdata[18:16] == master_prio[32:30] && master_prio[35:33] ==
        reg_rdata[18:16]) else $error("field and priority differ");
    a_write_lands: assert property (s_ctrl_wr ##2 1 |->
        master_prio[29:27] == $past(reg_wdata[14:12], 2) &&
        master_prio[32:30] == $past(reg_wdata[18:16], 2))
        else $error("control write not applied");
    a_fixed_defaults: assert property ($past(reset_n) |->
        master_prio[8:0] == 0 && master_prio[17:15] == 3'h7 &&
        master_prio[14:9] == 6'h24 && master_prio[23:21] == 3'h4)
        else $error("fixed priority wrong");
    a_legacy_inert: assert property (reg_wr &&
        reg_addr == prio_pkg::LEGACY_ADDR |=> ##1 $stable(master_prio))
        else $error("legacy write moved priorities");
    a_unmapped_zero: assert property (reg_rd &&
        reg_addr != prio_pkg::CONTROL_ADDR && reg_addr !=
        prio_pkg::LEGACY_ADDR |=> reg_rdata == 0) else $error("unmapped read");
    a_grant_lowest: assert property (grant.valid |->
        req_q[grant.index] && prio_q[3*grant.index+:3] == best)
        else $error("grant not lowest value");
    a_grant_present: assert property ($past(reset_n) |->
        grant.valid == |req_q) else $error("grant valid wrong");
endmodule : prio_checker
bind bus_master_priority_config prio_checker u_chk (.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .master_req(master_req), .master_prio(master_prio), .grant(grant));
`default_nettype wire

// ### verification/master_req_model.sv
// model of the bus masters: raises request levels on command
// assumes the commanded pattern changes right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module master_req_model (
    // clock, reset and command
    input wire logic         core_clk,
    input wire logic         reset_n,
    input wire logic [11:0]  pattern,
    // request levels
    output logic [11:0]      master_req
);
    // requests held one edge after the command, dropped in reset
    always_ff @(posedge core_clk or negedge reset_n)
        if (!reset_n)
            master_req <= 12'h000;
        else
            master_req <= pattern;
endmodule : master_req_model
`default_nettype wire

// ### verification/bus_master_priority_config_test.sv
// testbench: register and arbitration scenarios for the priority block
// assumes the checker is bound and the request model drives the masters
`timescale 1ns/1ps
`default_nettype none
module bus_master_priority_config_test;
    logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata;
    logic core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [11:0] pattern = 12'h0, master_req;
    logic [35:0] master_prio;
    prio_pkg::grant_t grant;
    int mismatches = 0, cmp_count = 0;
    bus_master_priority_config DUT (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_req(master_req),
        .master_prio(master_prio), .grant(grant));
    master_req_model masters (.core_clk(core_clk), .reset_n(reset_n),
        .pattern(pattern), .master_req(master_req));
    // expected priorities: usb/dsp cfg, disk, bridge/accel fields
    function automatic logic [35:0] tbl(logic [2:0] u, d, b);
        return {b, b, d, u, 3'h4, u, 3'h7, 3'h4, 3'h4, 9'h000};
    endfunction : tbl
    task automatic check(logic [35:0] seen, logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(logic [31:0] a, logic [31:0] d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [31:0] a, logic [31:0] exp);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check(36'(reg_rdata), 36'(exp));
    endtask : rd
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial forever #2 core_clk = ~core_clk;
    // watchdog against a hang
    initial begin
        repeat (2000) @(posedge core_clk);
        mismatches++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(prio_pkg::CONTROL_ADDR, 32'h00044400);
        check(master_prio, tbl(3'h4, 3'h4, 3'h4));
        wr(prio_pkg::CONTROL_ADDR, 32'hFFFBA9FF);
        rd(prio_pkg::CONTROL_ADDR, 32'h00032100);
        check(master_prio, tbl(3'h1, 3'h2, 3'h3));
        wr(prio_pkg::LEGACY_ADDR, 32'h12345678);
        rd(prio_pkg::LEGACY_ADDR, 32'h12345678);
        check(master_prio, tbl(3'h1, 3'h2, 3'h3));
        rd(32'h01C40044, 32'h0);
        // usb at value 1 beats ethernet at 4, then tc0/tc1 tie rotates
        @(posedge core_clk);
        pattern <= 12'h180;
        repeat (2) @(posedge core_clk);
        #1 check(36'(grant), 36'h18);
        @(posedge core_clk);
        pattern <= 12'h006;
        repeat (2) @(posedge core_clk);
        #1 check(36'(grant), 36'h11);
        @(posedge core_clk);
        #1 check(36'(grant), 36'h12);
        // reset in mid-run restores the defaults
        @(posedge core_clk);
        reset_n <= 1'b0;
        pattern <= 12'h000;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(prio_pkg::CONTROL_ADDR, 32'h00044400);
        check(master_prio, tbl(3'h4, 3'h4, 3'h4));
        test_done();
    end
endmodule : bus_master_priority_config_test
`default_nettype wire
